// *** testbench/key_switch_matrix.sv ***
// switch matrix model: six rows by five columns of contacts
// assumes rows pulled up; one key closed at a time from the bench
`timescale 1ns/1ps

module key_switch_matrix
(
   input wire [4:0] colLines,
   input wire keyDown,
   input wire [2:0] keyRow,
   input wire [2:0] keyCol,
   output wire [5:0] rowLines
);
   genvar r;
   generate
      for (r = 0; r < 6; r = r + 1)
      begin : g_row
         // pull-up unless the closed key sits on a low column
         assign rowLines[r] = !(keyDown && keyRow == r && colLines[keyCol] == 1'b0);
      end
   endgenerate
endmodule

// *** testbench/keypad_matrix_scanner_test.sv ***
// self-checking bench of the keypad scanner with a switch matrix model
// assumes the checker is bound in; short tick for simulation
`timescale 1ns/1ps
`include "keypad_scanner_defines.vh"

module keypad_matrix_scanner_test;
   reg mclk;
   reg sysRst;
   reg [15:0] regAddr;
   reg [7:0] regWrData;
   reg regWr;
   reg regRd;
   wire [7:0] regRdData;
   wire [5:0] rowIn;
   wire [4:0] colOut;
   reg powerDownBit;
   wire pdMuxSel;
   wire keyIrq;
   reg keyDown;
   reg [2:0] keyRow;
   reg [2:0] keyCol;
   reg [2:0] r;
   reg [2:0] c;
   reg [7:0] rd;
   integer n_errors;
   integer checked;
   integer i;
   integer w;
   reg [31:0] rnd;

   keypad_matrix_scanner #(.TICK_CYCLES(4)) i_dut (.mclk(mclk), .sys_rst(sysRst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData), .rowIn(rowIn),
      .colOut_ff(colOut), .powerDownBit(powerDownBit), .powerdownMuxSelect(pdMuxSel), .keyIrq(keyIrq));
   key_switch_matrix i_keys (.colLines(colOut), .keyDown(keyDown), .keyRow(keyRow), .keyCol(keyCol),
      .rowLines(rowIn));

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ----------------------------------------
   // expectations and bus tasks
   // ----------------------------------------
   function [7:0] keyCode(input [2:0] row, input [2:0] col);
      keyCode = {2'h0, row, col};
   endfunction

   function [7:0] intCtrl(input pd, input en, input flag);
      intCtrl = {pd, 5'h00, en, flag};
   endfunction

   task check(input string what, input [7:0] expVal, input [7:0] gotVal);
   begin
      checked = checked + 1;
      if (gotVal !== expVal)
      begin
         n_errors = n_errors + 1;
         $display("Error %s expected %h seen %h", what, expVal, gotVal);
      end
   end
   endtask

   task regWrite(input [15:0] addr, input [7:0] data);
   begin
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= addr;
      regWrData <= data;
      @(posedge mclk);
      regWr <= 1'b0;
      #1;
   end
   endtask

   task regRead(input [15:0] addr);
   begin
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= addr;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      rd = regRdData;
   end
   endtask

   task readCheck(input [15:0] addr, input [7:0] expVal, input string what);
   begin
      regRead(addr);
      check(what, expVal, rd);
   end
   endtask

   task setKey(input down, input [2:0] row, input [2:0] col);
   begin
      @(posedge mclk);
      keyDown <= down;
      keyRow <= row;
      keyCol <= col;
   end
   endtask

   task waitIrq;
   begin
      w = 0;
      while (keyIrq !== 1'b1 && w < 600)
      begin
         @(posedge mclk);
         w = w + 1;
      end
      #1;
   end
   endtask

   task wrap_up;
   begin
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask

   initial
   begin
      #4000000;
      n_errors = n_errors + 1;
      wrap_up;
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      sysRst = 1'b1;
      regAddr = 16'h0000;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      powerDownBit = 1'b0;
      keyDown = 1'b0;
      keyRow = 3'h0;
      keyCol = 3'h0;
      n_errors = 0;
      checked = 0;
      rnd = $urandom(52318);
      repeat (3) @(posedge mclk);
      sysRst <= 1'b0;
      readCheck(`KP_ADDR_MASTER_CLOCK, 8'h0a, "masterClock");
      readCheck(`KP_ADDR_KEY_INT_CTRL, 8'h00, "intCtrl");
      readCheck(16'h1234, 8'h00, "unmapped");
      setKey(1'b1, 3'h0, 3'h0);
      repeat (200) @(posedge mclk);
      check("idleColumns", 8'h1f, {3'h0, colOut});
      readCheck(`KP_ADDR_KEY_INT_CTRL, 8'h00, "noKeyYet");
      setKey(1'b0, 3'h0, 3'h0);
      regWrite(`KP_ADDR_KEY_INT_CTRL, 8'h02);
      // slot order 3,1,2,0,4: slot 0 drives column 3
      regWrite(`KP_ADDR_ORDER_LOW, 8'h8b);
      regWrite(`KP_ADDR_ORDER_HIGH, 8'h40);
      readCheck(`KP_ADDR_ORDER_LOW, 8'h8b, "orderLow");
      readCheck(`KP_ADDR_ORDER_HIGH, 8'h40, "orderHigh");
      regWrite(`KP_ADDR_SCAN_CTRL, 8'h01);
      @(posedge mclk);
      #1;
      check("firstColumn", 8'h17, {3'h0, colOut});
      for (i = 0; i < 6; i = i + 1)
      begin
         rnd = $urandom;
         r = (i == 0) ? 3'h5 : (i == 1) ? 3'h0 : 3'(rnd % 6);
         c = (i == 0) ? 3'h4 : (i == 1) ? 3'h0 : 3'((rnd >> 8) % 5);
         regWrite(`KP_ADDR_SCAN_TIMING, {2'h0, 2'(rnd >> 16), 2'h0, 2'(rnd >> 20)});
         setKey(1'b1, r, c);
         waitIrq;
         check("irqRaised", 8'h01, {7'h00, keyIrq});
         readCheck(`KP_ADDR_KEY_CODE, keyCode(r, c), "keyCode");
         readCheck(`KP_ADDR_KEY_INT_CTRL, intCtrl(1'b0, 1'b1, 1'b1), "flagSet");
         check("irqDropped", 8'h00, {7'h00, keyIrq});
         readCheck(`KP_ADDR_KEY_INT_CTRL, intCtrl(1'b0, 1'b1, 1'b0), "flagCleared");
         setKey(1'b0, r, c);
         repeat (300) @(posedge mclk);
      end
      regWrite(`KP_ADDR_KEY_INT_CTRL, 8'h80);
      check("muxSelect", 8'h01, {7'h00, pdMuxSel});
      setKey(1'b1, 3'h2, 3'h3);
      repeat (300) @(posedge mclk);
      check("maskedIrq", 8'h00, {7'h00, keyIrq});
      regRead(`KP_ADDR_EVT_STATUS);
      check("foundEvent", 8'h01, {7'h00, rd[`KP_EVT_FOUND]});
      regWrite(`KP_ADDR_EVT_ENABLE, 8'h01);
      check("eventIrq", 8'h01, {7'h00, keyIrq});
      regWrite(`KP_ADDR_EVT_CLEAR, 8'h07);
      check("eventCleared", 8'h00, {7'h00, keyIrq});
      readCheck(`KP_ADDR_EVT_STATUS, 8'h00, "eventStatus");
      regWrite(`KP_ADDR_EVT_ENABLE, 8'h00);
      readCheck(`KP_ADDR_KEY_INT_CTRL, intCtrl(1'b1, 1'b0, 1'b1), "maskedFlag");
      setKey(1'b0, 3'h2, 3'h3);
      repeat (300) @(posedge mclk);
      regWrite(`KP_ADDR_KEY_INT_CTRL, 8'h02);
      regWrite(`KP_ADDR_MASTER_CLOCK, 8'h4a);
      readCheck(`KP_ADDR_MASTER_CLOCK, 8'h4a, "gateSet");
      setKey(1'b1, 3'h1, 3'h2);
      repeat (300) @(posedge mclk);
      check("gatedIrq", 8'h00, {7'h00, keyIrq});
      setKey(1'b0, 3'h1, 3'h2);
      regWrite(`KP_ADDR_MASTER_CLOCK, 8'h0a);
      @(posedge mclk);
      powerDownBit <= 1'b1;
      setKey(1'b1, 3'h4, 3'h1);
      repeat (300) @(posedge mclk);
      check("powerDownIrq", 8'h00, {7'h00, keyIrq});
      readCheck(`KP_ADDR_MASTER_CLOCK, 8'h0a, "bitKept");
      @(posedge mclk);
      powerDownBit <= 1'b0;
      waitIrq;
      check("resumedIrq", 8'h01, {7'h00, keyIrq});
      readCheck(`KP_ADDR_KEY_CODE, keyCode(3'h4, 3'h1), "resumedCode");
      setKey(1'b0, 3'h4, 3'h1);
      repeat (100) @(posedge mclk);
      wrap_up;
   end
endmodule

// *** testbench/keypad_scanner_props.sv ***
// checker of the keypad scanner ports: reset, columns, bus, interrupt
// assumes it is bound to keypad_matrix_scanner
`timescale 1ns/1ps
`include "keypad_scanner_defines.vh"

module keypad_scanner_props #(
   parameter TICK_CYCLES = 4
)
(
   input wire mclk,
   input wire sys_rst,
   input wire [15:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   input wire [7:0] regRdData_ff,
   input wire [5:0] rowIn,
   input wire [4:0] colOut_ff,
   input wire powerDownBit,
   input wire powerdownMuxSelect,
   input wire keyIrq
);
   reg [7:0] mclkShadow_ff;
   reg pdMuxShadow_ff;
   reg irqEnShadow_ff;
   reg scanEnShadow_ff;
   reg [2:0] evtEnShadow_ff;

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // register shadows
   // ----------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         mclkShadow_ff <= `KP_RST_MASTER_CLOCK;
         pdMuxShadow_ff <= 1'b0;
         irqEnShadow_ff <= 1'b0;
         scanEnShadow_ff <= 1'b0;
         evtEnShadow_ff <= 3'h0;
      end
      else if (regWr)
      begin
         if (regAddr == `KP_ADDR_MASTER_CLOCK)
            mclkShadow_ff <= regWrData;
         if (regAddr == `KP_ADDR_KEY_INT_CTRL)
         begin
            pdMuxShadow_ff <= regWrData[7];
            irqEnShadow_ff <= regWrData[1];
         end
         if (regAddr == `KP_ADDR_SCAN_CTRL)
            scanEnShadow_ff <= regWrData[0];
         if (regAddr == `KP_ADDR_EVT_ENABLE)
            evtEnShadow_ff <= regWrData[2:0];
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence readOf(addr);
      regRd && regAddr == addr;
   endsequence

   AST_RESET_IDLE: assert property (disable iff (1'b0) sys_rst |=> colOut_ff == 5'h1f &&
      regRdData_ff == 8'h00 && !keyIrq && !powerdownMuxSelect) else $error("outputs not idle after reset");
   AST_ONE_COLUMN: assert property ($countones(~colOut_ff) <= 1) else $error("more than one column low");
   AST_MCLK_READ: assert property (readOf(`KP_ADDR_MASTER_CLOCK) |=>
      regRdData_ff == $past(mclkShadow_ff)) else $error("master clock read mismatch");
   AST_INTCTRL_READ: assert property (readOf(`KP_ADDR_KEY_INT_CTRL) |=>
      regRdData_ff[7:1] == {$past(pdMuxShadow_ff), 5'h00, $past(irqEnShadow_ff)}) else $error("int ctrl read bad");
   AST_POWERDOWN_MUX_SELECT_PIN: assert property (powerdownMuxSelect == pdMuxShadow_ff) else $error("mux select pin wrong");
   AST_IRQ_MASKED: assert property (!irqEnShadow_ff && evtEnShadow_ff == 3'h0 |-> !keyIrq)
      else $error("interrupt while masked");
   AST_IRQ_FLAG: assert property (readOf(`KP_ADDR_KEY_INT_CTRL) ##0 evtEnShadow_ff == 3'h0 |=>
      (regRdData_ff[1:0] == 2'h3) == $past(keyIrq)) else $error("interrupt not flag and enable");
   AST_PD_FREEZE: assert property (powerDownBit && scanEnShadow_ff && !regWr |=> $stable(colOut_ff))
      else $error("columns moved in power down");
   AST_GATE_FREEZE: assert property (mclkShadow_ff[`KP_MCLK_KEY_CLK_DIS] && scanEnShadow_ff && !regWr |=>
      $stable(colOut_ff))
      else $error("columns moved while clock gated");
   AST_SCAN_OFF: assert property (!scanEnShadow_ff && !$past(scanEnShadow_ff) |-> colOut_ff == 5'h1f)
      else $error("column driven while disabled");
endmodule

bind keypad_matrix_scanner keypad_scanner_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.mclk(mclk),
   .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData_ff(regRdData_ff), .rowIn(rowIn), .colOut_ff(colOut_ff), .powerDownBit(powerDownBit),
   .powerdownMuxSelect(powerdownMuxSelect), .keyIrq(keyIrq));

// *** verilog/keypad_matrix_scanner.v ***
// keypad matrix scanner: five driven columns, six sensed rows,
// debounce timer, key code capture, interrupt and clock gating
// assumes rows pulled up externally and synchronous to mclk;
// register port is a plain strobe bus with read data a cycle later
`timescale 1ns/1ps
`include "keypad_scanner_defines.vh"

module keypad_matrix_scanner #(
   parameter TICK_CYCLES = `KP_TICK_CYCLES
)
(
   input wire mclk,
   input wire sys_rst,
   input wire [15:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdData_ff,
   input wire [5:0] rowIn,
   output reg [4:0] colOut_ff,
   input wire powerDownBit,
   output wire powerdownMuxSelect,
   output wire keyIrq
);

   // ---------------------------------------------------------------
   // state codes
   // ---------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_SCAN = 2'h1;
   localparam [1:0] ST_DEBOUNCE = 2'h2;
   localparam [1:0] ST_RELEASE = 2'h3;
   localparam [2:0] LAST_SLOT = 3'h4;
   localparam [13:0] TICK_LAST = TICK_CYCLES - 1;
   localparam [7:0] INT_CTRL_RST = `KP_RST_KEY_INT_CTRL;
   localparam [7:0] ORDER_HIGH_RST = `KP_RST_ORDER_HIGH;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg [7:0] masterClock_ff;
   reg keyIrqEnable_ff;
   reg keyIrqFlag_ff;
   reg pdMuxSel_ff;
   reg [7:0] scanTiming_ff;
   reg [7:0] orderLow_ff;
   reg [6:0] orderHigh_ff;
   reg scanEnable_ff;
   reg [2:0] evtStatus_ff;
   reg [2:0] evtEnable_ff;
   reg [5:0] keyCode_ff;
   reg [1:0] state_ff;
   reg [2:0] slot_ff;
   reg [3:0] waitCnt_ff;
   reg [13:0] tickCnt_ff;
   reg [5:0] rowSnap_ff;

   reg [1:0] nxt_state;
   reg [2:0] nxt_slot;
   reg [3:0] nxt_waitCnt;
   reg [5:0] nxt_rowSnap;
   reg [5:0] nxt_keyCode;
   reg [4:0] nxt_colOut;
   reg evFound;
   reg evRelease;

   wire keyClockDisable;
   wire keyClockOn;
   wire tick;
   wire [14:0] orderAll;
   wire [2:0] slotCol [0:4];
   wire [2:0] curCol;
   wire [3:0] scanRate;
   wire [3:0] debounceTicks;
   wire anyRowLow;
   wire [4:0] colDrive;
   wire wrMaster;
   wire wrIntCtrl;
   wire rdIntCtrl;
   wire wrEvtClear;
   wire evOverrun;
   wire [2:0] evtSet;

   // ---------------------------------------------------------------
   // decode and gating
   // ---------------------------------------------------------------
   assign wrMaster = regWr && (regAddr == `KP_ADDR_MASTER_CLOCK);
   assign wrIntCtrl = regWr && (regAddr == `KP_ADDR_KEY_INT_CTRL);
   assign rdIntCtrl = regRd && (regAddr == `KP_ADDR_KEY_INT_CTRL);
   assign wrEvtClear = regWr && (regAddr == `KP_ADDR_EVT_CLEAR);

   assign keyClockDisable = masterClock_ff[`KP_MCLK_KEY_CLK_DIS];
   // register bit left alone in power-down, function still stops
   assign keyClockOn = !keyClockDisable && !powerDownBit;

   assign scanRate = scanTiming_ff[`KP_TIMING_RATE_LSB +: 4];
   assign debounceTicks = scanTiming_ff[`KP_TIMING_DEB_LSB +: 4];
   assign orderAll = {orderHigh_ff, orderLow_ff};
   assign anyRowLow = (rowIn != 6'h3F);
   assign tick = keyClockOn && (state_ff != ST_IDLE) && (tickCnt_ff == TICK_LAST);

   // ---------------------------------------------------------------
   // column order slots and drivers
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1)
      begin : gen_col
         assign slotCol[g] = orderAll[3 * g +: 3];
         assign colDrive[g] = !((nxt_state != ST_IDLE) &&
                                (slotCol[nxt_slot] == g));
      end
   endgenerate

   assign curCol = slotCol[slot_ff];

   // lowest numbered row pulled low
   function [2:0] firstLowRow;
      input [5:0] rows;
      integer i;
      begin
         firstLowRow = 3'h0;
         for (i = 5; i >= 0; i = i - 1)
         begin
            if (!rows[i])
            begin
               firstLowRow = i[2:0];
            end
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // tick divider
   // ---------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst || !scanEnable_ff || (state_ff == ST_IDLE))
      begin
         tickCnt_ff <= 14'h0000;
      end
      else if (keyClockOn)
      begin
         if (tickCnt_ff == TICK_LAST)
         begin
            tickCnt_ff <= 14'h0000;
         end
         else
         begin
            tickCnt_ff <= tickCnt_ff + 14'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // scan sequencer
   // ---------------------------------------------------------------
   always @*
   begin
      nxt_state = state_ff;
      nxt_slot = slot_ff;
      nxt_waitCnt = waitCnt_ff;
      nxt_rowSnap = rowSnap_ff;
      nxt_keyCode = keyCode_ff;
      evFound = 1'b0;
      evRelease = 1'b0;
      if (!scanEnable_ff)
      begin
         nxt_state = ST_IDLE;
         nxt_slot = 3'h0;
         nxt_waitCnt = 4'h0;
      end
      else if (keyClockOn)
      begin
         case (state_ff)
            ST_IDLE:
            begin
               nxt_state = ST_SCAN;
               nxt_slot = 3'h0;
               nxt_waitCnt = 4'h0;
            end
            ST_SCAN:
            begin
               if (tick)
               begin
                  if (waitCnt_ff == scanRate)
                  begin
                     nxt_waitCnt = 4'h0;
                     if (anyRowLow)
                     begin
                        nxt_state = ST_DEBOUNCE;
                        nxt_rowSnap = rowIn;
                     end
                     else
                     begin
                        nxt_slot = (slot_ff == LAST_SLOT) ? 3'h0 : slot_ff + 3'h1;
                     end
                  end
                  else
                  begin
                     nxt_waitCnt = waitCnt_ff + 4'h1;
                  end
               end
            end
            ST_DEBOUNCE:
            begin
               if (tick)
               begin
                  if (waitCnt_ff == debounceTicks)
                  begin
                     nxt_waitCnt = 4'h0;
                     if (rowIn == rowSnap_ff)
                     begin
                        nxt_state = ST_RELEASE;
                        nxt_keyCode = {firstLowRow(rowSnap_ff), curCol};
                        evFound = 1'b1;
                     end
                     else
                     begin
                        nxt_state = ST_SCAN;
                        nxt_slot = (slot_ff == LAST_SLOT) ? 3'h0 : slot_ff + 3'h1;
                     end
                  end
                  else
                  begin
                     nxt_waitCnt = waitCnt_ff + 4'h1;
                  end
               end
            end
            default:
            begin
               if (tick && !anyRowLow)
               begin
                  nxt_state = ST_SCAN;
                  nxt_waitCnt = 4'h0;
                  nxt_slot = (slot_ff == LAST_SLOT) ? 3'h0 : slot_ff + 3'h1;
                  evRelease = 1'b1;
               end
            end
         endcase
      end
   end

   always @*
   begin
      nxt_colOut = colDrive;
   end

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_ff <= ST_IDLE;
         slot_ff <= 3'h0;
         waitCnt_ff <= 4'h0;
         rowSnap_ff <= 6'h3F;
         keyCode_ff <= 6'h00;
         colOut_ff <= 5'h1F;
      end
      else
      begin
         state_ff <= nxt_state;
         slot_ff <= nxt_slot;
         waitCnt_ff <= nxt_waitCnt;
         rowSnap_ff <= nxt_rowSnap;
         keyCode_ff <= nxt_keyCode;
         // columns hold while the keypad clock is stopped with scanning enabled; with scanning off they still return to idle
         if (!scanEnable_ff || keyClockOn)
         begin
            colOut_ff <= nxt_colOut;
         end
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         masterClock_ff <= `KP_RST_MASTER_CLOCK;
         keyIrqEnable_ff <= INT_CTRL_RST[`KP_INT_IRQ_EN];
         pdMuxSel_ff <= INT_CTRL_RST[`KP_INT_PD_MUX];
         scanTiming_ff <= `KP_RST_SCAN_TIMING;
         orderLow_ff <= `KP_RST_ORDER_LOW;
         orderHigh_ff <= ORDER_HIGH_RST[6:0];
         scanEnable_ff <= 1'b0;
         evtEnable_ff <= `KP_RST_EVT;
      end
      else if (regWr)
      begin
         if (wrMaster)
         begin
            masterClock_ff <= regWrData;
         end
         else if (wrIntCtrl)
         begin
            keyIrqEnable_ff <= regWrData[`KP_INT_IRQ_EN];
            pdMuxSel_ff <= regWrData[`KP_INT_PD_MUX];
         end
         else if (regAddr == `KP_ADDR_SCAN_TIMING)
         begin
            scanTiming_ff <= regWrData;
         end
         else if (regAddr == `KP_ADDR_ORDER_LOW)
         begin
            orderLow_ff <= regWrData;
         end
         else if (regAddr == `KP_ADDR_ORDER_HIGH)
         begin
            orderHigh_ff <= regWrData[6:0];
         end
         else if (regAddr == `KP_ADDR_SCAN_CTRL)
         begin
            scanEnable_ff <= regWrData[`KP_CTRL_SCAN_EN];
         end
         else if (regAddr == `KP_ADDR_EVT_ENABLE)
         begin
            evtEnable_ff <= regWrData[2:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // key flag and event status
   // ---------------------------------------------------------------
   assign evOverrun = evFound && keyIrqFlag_ff;
   assign evtSet = {evOverrun, evRelease, evFound};

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         keyIrqFlag_ff <= 1'b0;
         evtStatus_ff <= `KP_RST_EVT;
      end
      else
      begin
         // a new key in the reading cycle keeps the flag set
         if (evFound)
         begin
            keyIrqFlag_ff <= 1'b1;
         end
         else if (rdIntCtrl)
         begin
            keyIrqFlag_ff <= 1'b0;
         end
         if (wrEvtClear)
         begin
            evtStatus_ff <= (evtStatus_ff & ~regWrData[2:0]) | evtSet;
         end
         else
         begin
            evtStatus_ff <= evtStatus_ff | evtSet;
         end
      end
   end

   assign keyIrq = (keyIrqFlag_ff && keyIrqEnable_ff) ||
                   ((evtStatus_ff & evtEnable_ff) != 3'h0);
   assign powerdownMuxSelect = pdMuxSel_ff;

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         regRdData_ff <= 8'h00;
      end
      else if (!regRd)
      begin
         regRdData_ff <= 8'h00;
      end
      else if (regAddr == `KP_ADDR_MASTER_CLOCK)
      begin
         regRdData_ff <= masterClock_ff;
      end
      else if (regAddr == `KP_ADDR_KEY_INT_CTRL)
      begin
         regRdData_ff <= {pdMuxSel_ff, 5'h00, keyIrqEnable_ff, keyIrqFlag_ff};
      end
      else if (regAddr == `KP_ADDR_SCAN_TIMING)
      begin
         regRdData_ff <= scanTiming_ff;
      end
      else if (regAddr == `KP_ADDR_ORDER_LOW)
      begin
         regRdData_ff <= orderLow_ff;
      end
      else if (regAddr == `KP_ADDR_ORDER_HIGH)
      begin
         regRdData_ff <= {1'b0, orderHigh_ff};
      end
      else if (regAddr == `KP_ADDR_SCAN_STATE)
      begin
         regRdData_ff <= {1'b0, keyClockOn, state_ff, 1'b0, slot_ff};
      end
      else if (regAddr == `KP_ADDR_SCAN_CTRL)
      begin
         regRdData_ff <= {7'h00, scanEnable_ff};
      end
      else if (regAddr == `KP_ADDR_EVT_STATUS)
      begin
         regRdData_ff <= {5'h00, evtStatus_ff};
      end
      else if (regAddr == `KP_ADDR_EVT_ENABLE)
      begin
         regRdData_ff <= {5'h00, evtEnable_ff};
      end
      else if (regAddr == `KP_ADDR_KEY_CODE)
      begin
         regRdData_ff <= {2'h0, keyCode_ff};
      end
      else
      begin
         regRdData_ff <= 8'h00;
      end
   end

endmodule

// *** verilog/keypad_scanner_defines.vh ***
// register offsets, field positions, reset values and timing counts
// for the keypad matrix scanner; included by its bare name
`ifndef KEYPAD_SCANNER_DEFINES_VH
`define KEYPAD_SCANNER_DEFINES_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define KP_ADDR_MASTER_CLOCK 16'h008F
`define KP_ADDR_KEY_INT_CTRL 16'hFF94
`define KP_ADDR_SCAN_TIMING 16'hFF90
`define KP_ADDR_ORDER_LOW 16'hFF91
`define KP_ADDR_ORDER_HIGH 16'hFF92
`define KP_ADDR_SCAN_STATE 16'hFF93
`define KP_ADDR_SCAN_CTRL 16'hFF95
`define KP_ADDR_EVT_STATUS 16'hFF96
`define KP_ADDR_EVT_CLEAR 16'hFF97
`define KP_ADDR_EVT_ENABLE 16'hFF98
`define KP_ADDR_KEY_CODE 16'hFF99

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define KP_MCLK_KEY_CLK_DIS 6
`define KP_INT_PD_MUX 7
`define KP_INT_IRQ_EN 1
`define KP_INT_IRQ_FLAG 0
`define KP_CTRL_SCAN_EN 0
`define KP_TIMING_RATE_LSB 0
`define KP_TIMING_DEB_LSB 4
`define KP_EVT_FOUND 0
`define KP_EVT_RELEASE 1
`define KP_EVT_OVERRUN 2

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define KP_RST_MASTER_CLOCK 8'h0A
`define KP_RST_KEY_INT_CTRL 8'h00
`define KP_RST_SCAN_TIMING 8'h0_0
`define KP_RST_ORDER_LOW 8'h88
`define KP_RST_ORDER_HIGH 8'h46
`define KP_RST_SCAN_CTRL 8'h00
`define KP_RST_EVT 3'h0

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define KP_CLK_MHZ 10
`define KP_TICK_US 1000
`define KP_TICK_CYCLES (`KP_TICK_US * `KP_CLK_MHZ)

`endif
